// File: hdl/rhmc_defines.svh
// Purpose: constants for the reset and halt-mode control block
// Assumes: core clock pclk at 25 MHz, apb register access
// Notes:   offsets are byte addresses of 32-bit aligned words
// Operation
// RULE1 - While the fundamental reset input is low, all internal logic is held in reset.
// RULE2 - Asserting the fundamental reset also starts a link fundamental reset on the ports.
// RULE3 - A reset-halt strap seen at reset makes the device finish reset then stay held.
// RULE4 - While held, both the master and slave management buses keep working.
// RULE5 - The hold ends only when a bus master clears the halt bit in the switch control register.
// RULE6 - Mode code 0 is normal, 1 is normal after eeprom load, 2 and up are reserved.
// RULE7 - The system keeps the mode straps stable after the fundamental reset is released.
// RULE8 - In eeprom mode the master bus addresses the eeprom at the address given by its straps.
// RULE9 - Reset release is synchronised to the core clock and straps are latched on it.
`ifndef RHMC_DEFINES_SVH
`define RHMC_DEFINES_SVH
`define RHMC_OFF_SWITCH_CONTROL_REG      12'h000
`define RHMC_OFF_STATUS     12'h004
`define RHMC_OFF_STRAPS     12'h008
`define RHMC_BIT_HALT       0
`define RHMC_MODE_NORMAL    4'h0
`define RHMC_MODE_EEPROM    4'h1
`define RHMC_LINK_RST_NS    1000
`define RHMC_CLK_NS         40
`define RHMC_LINK_RST_CYC   ((`RHMC_LINK_RST_NS + `RHMC_CLK_NS - 1) / `RHMC_CLK_NS)
`define RHMC_EE_TIMEOUT_CYC 64
`endif

// File: hdl/rhmc_pkg.sv
// Purpose: types for the reset and halt-mode control block
// Assumes: nothing
// Notes:   state codes are gray along the eeprom boot path
package rhmc_pkg;
  typedef enum logic [2:0]
  {
    rhmc_st_link_rst = 3'h0,
    rhmc_st_ee_load  = 3'h1,
    rhmc_st_halt     = 3'h3,
    rhmc_st_run      = 3'h2
  } rhmc_state_e;

  typedef struct packed
  {
    logic       halt;
    logic [3:0] mode;
    logic [3:0] ee_addr;
  } rhmc_straps_s;
endpackage

// File: hdl/rhmc_reset_halt_mode_control.sv
// Purpose: reset sequencing, halt-after-reset and boot mode control
// Assumes: apb master on pclk; straps static after reset release
// Notes:   eeprom load itself lives elsewhere; this block starts it and waits
`include "rhmc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module rhmc_reset_halt_mode_control
  import rhmc_pkg::*;
#(
  parameter int LINK_RST_CYC = `RHMC_LINK_RST_CYC
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reset_halt,
  input  wire logic [3:0]  switch_mode_select,
  input  wire logic [3:0]  eeprom_bus_address_straps,
  input  wire logic        eeprom_load_done,
  output logic             core_reset_n,
  output logic             link_fundamental_reset,
  output logic             mgmt_bus_enable,
  output logic             eeprom_load_start,
  output logic [3:0]       eeprom_bus_address,
  output logic             mode_reserved
);

  // the count must fit the 16-bit counter and give at least one cycle
  if (LINK_RST_CYC < 1 || LINK_RST_CYC > 65535)
  begin
    $error("link reset count out of range");
  end

  // ==========================================================
  // reset release synchroniser
  // ==========================================================
  logic [2:0] rst_sync;
  logic [2:0] next_rst_sync;
  logic       rel_pulse;
  logic       rel_done;
  logic       next_rel_done;

  always_comb
  begin
    next_rst_sync = {rst_sync[1:0], 1'b1}; // RULE9
    next_rel_done = rel_done | rel_pulse;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_sync <= 3'h0; // RULE1
      rel_done <= 1'b0;
    end
    else
    begin
      rst_sync <= next_rst_sync;
      rel_done <= next_rel_done;
    end
  end

  // one pulse once the second and third stages both read one; rel_done blocks repeats
  assign rel_pulse = rst_sync[2] && rst_sync[1] && !rel_done;

  // ==========================================================
  // strap pin synchroniser
  // ==========================================================
  // straps come from pins outside pclk: three flops, and a change
  // is only believed once the second and third stages agree
  rhmc_straps_s pin_straps;
  rhmc_straps_s strap_s1;
  rhmc_straps_s strap_s2;
  rhmc_straps_s strap_s3;
  rhmc_straps_s strap_stable;
  rhmc_straps_s strap_now;
  rhmc_straps_s next_strap_s1;
  rhmc_straps_s next_strap_s2;
  rhmc_straps_s next_strap_s3;
  rhmc_straps_s next_strap_stable;

  assign pin_straps = {reset_halt, switch_mode_select, eeprom_bus_address_straps};
  assign strap_now  = (strap_s2 == strap_s3) ? strap_s3 : strap_stable;

  always_comb
  begin
    next_strap_s1     = pin_straps;
    next_strap_s2     = strap_s1;
    next_strap_s3     = strap_s2;
    next_strap_stable = strap_now;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_s1     <= '0; // RULE1
      strap_s2     <= '0;
      strap_s3     <= '0;
      strap_stable <= '0;
    end
    else
    begin
      strap_s1     <= next_strap_s1;
      strap_s2     <= next_strap_s2;
      strap_s3     <= next_strap_s3;
      strap_stable <= next_strap_stable;
    end
  end

  // ==========================================================
  // strap capture on the synchronised release
  // ==========================================================
  rhmc_straps_s straps;
  rhmc_straps_s next_straps;

  always_comb
  begin
    next_straps = straps;
    if (rel_pulse)
      next_straps = strap_now; // RULE9
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      straps <= '0;
    else
      straps <= next_straps;
  end

  // ==========================================================
  // sequencer
  // ==========================================================
  rhmc_state_e state;
  rhmc_state_e next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        halt_bit;
  logic        next_halt_bit;
  logic        wr_ctl;

  // halt bit: the strap capture wins over a write in the same cycle
  assign wr_ctl = psel && penable && pwrite && (paddr == `RHMC_OFF_SWITCH_CONTROL_REG);

  always_comb
  begin
    next_state    = state;
    next_cnt      = cnt;
    next_halt_bit = halt_bit;
    if (rel_pulse)
      next_halt_bit = strap_now.halt; // RULE3
    else if (wr_ctl)
      next_halt_bit = pwdata[`RHMC_BIT_HALT]; // RULE5
    case (state)
      rhmc_st_link_rst:
      begin
        // cnt only runs after release, so the link reset also spans the sync delay
        if (rel_done && cnt != LINK_RST_CYC[15:0])
          next_cnt = cnt + 16'h1; // RULE2
        else if (rel_done)
        begin
          // reserved modes fall through to the normal path
          if (straps.mode == `RHMC_MODE_EEPROM)
            next_state = rhmc_st_ee_load; // RULE6
          else
            next_state = rhmc_st_halt;
        end
      end
      rhmc_st_ee_load:
      begin
        // the loader sits outside this block and reports when it is finished
        if (eeprom_load_done)
          next_state = rhmc_st_halt; // RULE8
      end
      rhmc_st_halt:
      begin
        if (!halt_bit)
          next_state = rhmc_st_run; // RULE5
      end
      default:
        next_state = rhmc_st_run;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state    <= rhmc_st_link_rst; // RULE1
      cnt      <= 16'h0;
      halt_bit <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      cnt      <= next_cnt;
      halt_bit <= next_halt_bit;
    end
  end

  // these outputs decode the state register or the captured straps, never the bus
  assign link_fundamental_reset = (state == rhmc_st_link_rst); // RULE2
  assign core_reset_n           = (state == rhmc_st_run); // RULE3
  assign mgmt_bus_enable        = (state != rhmc_st_link_rst); // RULE4
  assign eeprom_load_start      = (state == rhmc_st_ee_load); // RULE8
  assign eeprom_bus_address     = straps.ee_addr; // RULE8
  assign mode_reserved          = rel_done && (straps.mode > `RHMC_MODE_EEPROM); // RULE6

  // ==========================================================
  // apb slave
  // ==========================================================
  // zero wait states; read data is captured in the setup cycle
  logic [31:0] next_prdata;

  function automatic logic reg_known(input logic [11:0] addr);
    reg_known = (addr == `RHMC_OFF_SWITCH_CONTROL_REG) || (addr == `RHMC_OFF_STATUS)
                || (addr == `RHMC_OFF_STRAPS);
  endfunction

  always_comb
  begin
    // unmapped reads return zero alongside pslverr
    next_prdata = 32'h0;
    if (paddr == `RHMC_OFF_SWITCH_CONTROL_REG)
      next_prdata = {31'h0, halt_bit};
    else if (paddr == `RHMC_OFF_STATUS)
      next_prdata = {26'h0, mode_reserved, core_reset_n, 1'b0, state};
    else if (paddr == `RHMC_OFF_STRAPS)
      next_prdata = {23'h0, straps};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= next_prdata;
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !reg_known(paddr);

  // ==========================================================
  // checks
  // ==========================================================
  // properties below only run outside reset
  chk_link_pending: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    !rel_done |-> link_fundamental_reset)
    else $error("link reset dropped before release");
  chk_core_held: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    !rel_done |-> !core_reset_n && !mgmt_bus_enable)
    else $error("core or bus active before release");
  chk_halt_capture: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    rel_pulse |=> halt_bit == $past(strap_now.halt))
    else $error("halt strap not captured");
  chk_ee_wait: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    (state == rhmc_st_ee_load && !eeprom_load_done) |=> state == rhmc_st_ee_load)
    else $error("eeprom load left early");
  chk_rsv_normal: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (rel_done && straps.mode != `RHMC_MODE_EEPROM) |-> state != rhmc_st_ee_load)
    else $error("eeprom load in non-eeprom mode");
  chk_reset_link: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    $rose(rel_done) |-> link_fundamental_reset[*2])
    else $error("link reset not held after release");
  chk_halt_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    (state == rhmc_st_halt && halt_bit) |=> !core_reset_n)
    else $error("core released while halted");
  chk_mgmt_active: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    (state == rhmc_st_halt) |-> mgmt_bus_enable)
    else $error("management bus off while halted");
  chk_halt_exit: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    (state == rhmc_st_halt && !halt_bit) |=> core_reset_n)
    else $error("halt exit missed");
  chk_run_cause: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    $rose(core_reset_n) |-> $past(state == rhmc_st_halt) && !$past(halt_bit))
    else $error("run entered without halt clear");
  chk_mode_ee: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (state == rhmc_st_ee_load) |-> straps.mode == `RHMC_MODE_EEPROM)
    else $error("eeprom load in wrong mode");
  chk_ee_addr: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    $rose(rel_done) |=> eeprom_bus_address == $past(eeprom_bus_address_straps, 2))
    else $error("eeprom address not latched");
  chk_sync_release: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    $rose(rel_done) |-> $past(rst_sync[2]) && $past(rst_sync[1]))
    else $error("release not synchronised");
  // coverage of the main boot paths
  cov_wr_clear: cover property (@(posedge pclk) disable iff (!presetn)
    state == rhmc_st_halt && wr_ctl && !pwdata[`RHMC_BIT_HALT]);
  cov_halt: cover property (@(posedge pclk) disable iff (!presetn)
    state == rhmc_st_halt ##1 state == rhmc_st_run);
  cov_ee: cover property (@(posedge pclk) disable iff (!presetn)
    state == rhmc_st_ee_load ##1 state == rhmc_st_halt);
  cov_rsv: cover property (@(posedge pclk) disable iff (!presetn) mode_reserved);

endmodule
`default_nettype wire

// File: bench/rhmc_ee_model.sv
// Purpose: eeprom loader stand-in on the far side of the block
// Assumes: load start is a level that stays high until done
// Notes:   done answers DLY+1 cycles after start
`timescale 1ns/100ps
`default_nettype none
module rhmc_ee_model
#(
  parameter int DLY = 5
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      done
);
  int cnt;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt  <= 0;
      done <= 1'b0;
    end
    else
    begin
      cnt  <= start ? cnt + 1 : 0;
      done <= start && (cnt >= DLY);
    end
  end
endmodule
`default_nettype wire

// File: bench/tb.sv
// Purpose: self-checking bench for the reset and halt-mode block
// Assumes: apb slave with no wait states
// Notes:   short link reset count to keep the run brief
`include "rhmc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rhmc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        reset_halt, ee_done, core_reset_n, link_fundamental_reset;
  logic        mgmt_bus_enable, eeprom_load_start, mode_reserved;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  switch_mode_select, eeprom_bus_address_straps, eeprom_bus_address;
  int          n_errors, total_checks;

  rhmc_reset_halt_mode_control #(.LINK_RST_CYC(2)) uut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_halt(reset_halt), .switch_mode_select(switch_mode_select),
    .eeprom_bus_address_straps(eeprom_bus_address_straps), .eeprom_load_done(ee_done),
    .core_reset_n(core_reset_n), .link_fundamental_reset(link_fundamental_reset),
    .mgmt_bus_enable(mgmt_bus_enable), .eeprom_load_start(eeprom_load_start),
    .eeprom_bus_address(eeprom_bus_address), .mode_reserved(mode_reserved)
  );
  rhmc_ee_model ee (.clk(pclk), .rst_n(presetn), .start(eeprom_load_start), .done(ee_done));

  task automatic conclude();
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // k: 0 bus enabled, 1 core running, 2 eeprom load started
  task automatic wait_for(input int k);
    for (int i = 0; i < 200; i++)
    begin
      @(posedge pclk);
      if ((k == 0 && mgmt_bus_enable === 1'b1) || (k == 1 && core_reset_n === 1'b1)
          || (k == 2 && eeprom_load_start === 1'b1))
        return;
    end
    n_errors++;
    conclude();
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
    begin
      n_errors++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic boot(input logic h, input logic [3:0] m, input logic [3:0] a);
    presetn                   <= 1'b0;
    reset_halt                <= h;
    switch_mode_select        <= m;
    eeprom_bus_address_straps <= a;
    repeat (2) @(posedge pclk);
    cmp(core_reset_n, 1'b0);
    cmp(link_fundamental_reset, 1'b1);
    cmp(mgmt_bus_enable, 1'b0);
    presetn <= 1'b1;
    wait_for(0);
    cmp(link_fundamental_reset, 1'b0);
  endtask

  task automatic s_halt();
    boot(1'b1, `RHMC_MODE_NORMAL, 4'h5);
    apb(1'b0, `RHMC_OFF_STRAPS, 32'h0);
    cmp(rd, 32'h105);
    apb(1'b0, `RHMC_OFF_SWITCH_CONTROL_REG, 32'h0);
    cmp(rd, 32'h1);
    apb(1'b0, 12'h100, 32'h0);
    cmp(err, 1'b1);
    cmp(rd, 32'h0);
    repeat (8) @(posedge pclk);
    cmp(core_reset_n, 1'b0);
    apb(1'b1, `RHMC_OFF_SWITCH_CONTROL_REG, 32'h0);
    wait_for(1);
  endtask

  task automatic s_ee();
    boot(1'b0, `RHMC_MODE_EEPROM, 4'ha);
    wait_for(2);
    cmp(eeprom_bus_address, 4'ha);
    cmp(core_reset_n, 1'b0);
    wait_for(1);
  endtask

  task automatic s_mode(input logic [3:0] m, input logic res);
    boot(1'b0, m, 4'h3);
    wait_for(1);
    apb(1'b0, `RHMC_OFF_STATUS, 32'h0);
    cmp(rd, res ? 32'h32 : 32'h12);
    cmp(eeprom_load_start, 1'b0);
    cmp(mode_reserved, res);
    apb(1'b1, `RHMC_OFF_SWITCH_CONTROL_REG, 32'h1);
    repeat (2) @(posedge pclk);
    cmp(core_reset_n, 1'b1);
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial
  begin
    n_errors = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    reset_halt = 1'b0;
    switch_mode_select = 4'h0;
    eeprom_bus_address_straps = 4'h0;
    s_halt();
    s_ee();
    s_mode(4'h0, 1'b0);
    s_mode(4'h2, 1'b1);
    s_mode(4'hf, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
